//--- adc_seq_consts.vh
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// --------------------------------------------------
// register byte offsets
// --------------------------------------------------
`define OFS_MODE_CTRL     12'h000
`define OFS_SINGLE_CTRL1  12'h004
`define OFS_SCAN_CTRL0    12'h008
`define OFS_SCAN_CTRL1    12'h00c
`define OFS_STATUS        12'h010
`define OFS_CMP_RESULT    12'h014
`define OFS_IRQ_STATUS    12'h018
`define OFS_IRQ_ENABLE    12'h01c
`define OFS_IRQ_CLEAR     12'h020
`define OFS_RESULT10_BASE 12'h040
`define OFS_RESULT8_BASE  12'h080
`define RESULT_WIN_MASK   12'hfc0

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define MODE_SCAN_BIT     0
`define MODE_COMPARE_BIT  1
`define MODE_DMA_BIT      2
`define MODE_START_BIT    8
`define SCAN_CONT_BIT     0
`define SCAN_STOP_BIT     2
`define STATUS_BUSY_BIT   0
`define EVT_SINGLE_BIT    0
`define EVT_SCAN_BIT      1

// --------------------------------------------------
// widths and reset values
// --------------------------------------------------
`define NUM_CHANNELS      16
`define CH_W              4
`define RESULT_W          10
`define EVT_W             2
`define MODE_CTRL_RST     3'h0
`define CHAN_SEL_RST      4'h0
`define SCAN_CONT_RST     1'b0
`define EVT_RST           2'h0

// --------------------------------------------------
// timing counts
// --------------------------------------------------
`define APB_WAIT_CYCLES   1

`endif

//--- adc_sequencer.v
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_sequencer (
  // apb clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 ce,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg                  pready,
  output reg  [31:0]          prdata,
  output reg                  pslverr,
  // analog converter core
  output reg                  conv_start,
  output reg  [`CH_W-1:0]     conv_channel,
  output reg                  conv_compare,
  input  wire                 conv_done,
  input  wire [`RESULT_W-1:0] conv_result,
  input  wire                 cmp_flag,
  // requests
  output reg                  irq,
  output reg                  dma_req
);

  // --------------------------------------------------
  // states
  // --------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // --------------------------------------------------
  // helper functions
  // --------------------------------------------------
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr[11:2] == ofs[11:2]);
    end
  endfunction

  function in_window;
    input [11:0] addr;
    input [11:0] base;
    begin
      in_window = ((addr & `RESULT_WIN_MASK) == base);
    end
  endfunction

  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  reg  [2:0]            mode_reg;
  reg  [`CH_W-1:0]      single_ch_reg;
  reg                   scan_cont_reg;
  reg  [`CH_W-1:0]      last_ch_reg;
  reg  [15:0]           cmp_result_reg;
  reg  [1:0]            state_reg;
  reg  [1:0]            state_next;
  reg  [`CH_W-1:0]      ch_reg;
  reg  [`CH_W-1:0]      ch_next;
  reg                   scan_run_reg;
  reg                   cmp_run_reg;
  reg  [`EVT_W-1:0]     evt;
  reg                   mem_wr;
  reg                   cmp_wr;
  reg  [31:0]           rdata_mux;
  reg                   addr_ok;
  wire                  access;
  wire                  wr_now;
  wire                  start_wr;
  wire                  stop_wr;
  wire                  busy;
  wire [`RESULT_W-1:0]  mem_rdata;
  wire [`EVT_W-1:0]     irq_status;
  wire [`EVT_W-1:0]     irq_enable;
  wire                  irq_w;

  assign access   = psel & penable;
  assign wr_now   = access & pready & pwrite & addr_ok;
  assign start_wr = wr_now & hit(paddr, `OFS_MODE_CTRL) & pwdata[`MODE_START_BIT];
  assign stop_wr  = wr_now & hit(paddr, `OFS_SCAN_CTRL0) & pwdata[`SCAN_STOP_BIT];
  assign busy     = (state_reg != ST_IDLE);

  // --------------------------------------------------
  // address decode and read mux
  // --------------------------------------------------
  always @* begin
    addr_ok   = 1'b1;
    rdata_mux = 32'h0000_0000;
    if (hit(paddr, `OFS_MODE_CTRL)) begin
      rdata_mux[2:0] = mode_reg;
    end else if (hit(paddr, `OFS_SINGLE_CTRL1)) begin
      rdata_mux[`CH_W-1:0] = single_ch_reg;
    end else if (hit(paddr, `OFS_SCAN_CTRL0)) begin
      rdata_mux[`SCAN_CONT_BIT] = scan_cont_reg;
    end else if (hit(paddr, `OFS_SCAN_CTRL1)) begin
      rdata_mux[`CH_W-1:0] = last_ch_reg;
    end else if (hit(paddr, `OFS_STATUS)) begin
      rdata_mux[`STATUS_BUSY_BIT] = busy;
      rdata_mux[7:4]              = ch_reg;
    end else if (hit(paddr, `OFS_CMP_RESULT)) begin
      rdata_mux[15:0] = cmp_result_reg;
    end else if (hit(paddr, `OFS_IRQ_STATUS)) begin
      rdata_mux[`EVT_W-1:0] = irq_status;
    end else if (hit(paddr, `OFS_IRQ_ENABLE)) begin
      rdata_mux[`EVT_W-1:0] = irq_enable;
    end else if (hit(paddr, `OFS_IRQ_CLEAR)) begin
      rdata_mux = 32'h0000_0000;
    end else if (in_window(paddr, `OFS_RESULT10_BASE)) begin
      rdata_mux[`RESULT_W-1:0] = mem_rdata;
    end else if (in_window(paddr, `OFS_RESULT8_BASE)) begin
      rdata_mux[7:0] = mem_rdata[`RESULT_W-1:2];
    end else begin
      addr_ok = 1'b0;
    end
  end

  // --------------------------------------------------
  // apb handshake, one wait state
  // --------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= access & ~pready;
      if (access & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_mux;
        pslverr <= ~addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // control registers
  // --------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= `MODE_CTRL_RST;
      single_ch_reg <= `CHAN_SEL_RST;
      scan_cont_reg <= `SCAN_CONT_RST;
      last_ch_reg   <= `CHAN_SEL_RST;
    end else if (ce && wr_now) begin
      if (hit(paddr, `OFS_MODE_CTRL)) begin
        mode_reg <= pwdata[2:0];
      end
      if (hit(paddr, `OFS_SINGLE_CTRL1)) begin
        single_ch_reg <= pwdata[`CH_W-1:0];
      end
      if (hit(paddr, `OFS_SCAN_CTRL0)) begin
        scan_cont_reg <= pwdata[`SCAN_CONT_BIT];
      end
      if (hit(paddr, `OFS_SCAN_CTRL1)) begin
        last_ch_reg <= pwdata[`CH_W-1:0];
      end
    end
  end

  // --------------------------------------------------
  // sequencer
  // --------------------------------------------------
  always @* begin
    state_next = state_reg;
    ch_next    = ch_reg;
    evt        = `EVT_RST;
    mem_wr     = 1'b0;
    cmp_wr     = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_wr) begin
          state_next = ST_REQ;
          if (pwdata[`MODE_SCAN_BIT] & ~pwdata[`MODE_COMPARE_BIT]) begin
            ch_next = {`CH_W{1'b0}};
          end else begin
            ch_next = single_ch_reg;
          end
        end
      end
      ST_REQ: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done) begin
          if (cmp_run_reg) begin
            cmp_wr = 1'b1;
          end else begin
            mem_wr = 1'b1;
          end
          if (!scan_run_reg) begin
            state_next              = ST_IDLE;
            evt[`EVT_SINGLE_BIT]    = 1'b1;
          end else if (ch_reg == last_ch_reg) begin
            evt[`EVT_SCAN_BIT] = 1'b1;
            if (scan_cont_reg) begin
              ch_next    = {`CH_W{1'b0}};
              state_next = ST_REQ;
            end else begin
              state_next = ST_IDLE;
            end
          end else begin
            ch_next    = ch_reg + 4'h1;
            state_next = ST_REQ;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (stop_wr && busy) begin
      state_next = ST_IDLE;
      evt        = `EVT_RST;
      mem_wr     = 1'b0;
      cmp_wr     = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      ch_reg         <= {`CH_W{1'b0}};
      scan_run_reg   <= 1'b0;
      cmp_run_reg    <= 1'b0;
      cmp_result_reg <= 16'h0000;
      conv_start     <= 1'b0;
      conv_channel   <= {`CH_W{1'b0}};
      conv_compare   <= 1'b0;
      dma_req        <= 1'b0;
    end else if (ce) begin
      state_reg  <= state_next;
      ch_reg     <= ch_next;
      conv_start <= (state_next == ST_REQ);
      if (state_next == ST_REQ) begin
        conv_channel <= ch_next;
      end
      if (state_reg == ST_IDLE && start_wr) begin
        scan_run_reg <= pwdata[`MODE_SCAN_BIT] & ~pwdata[`MODE_COMPARE_BIT];
        cmp_run_reg  <= pwdata[`MODE_COMPARE_BIT];
        conv_compare <= pwdata[`MODE_COMPARE_BIT];
      end
      if (cmp_wr) begin
        cmp_result_reg[ch_reg] <= cmp_flag;
      end
      dma_req <= (|evt) & mode_reg[`MODE_DMA_BIT];
    end
  end

  // --------------------------------------------------
  // result storage
  // --------------------------------------------------
  result_mem u_mem (
    .pclk    (pclk),
    .ce      (ce),
    .wr_en   (mem_wr),
    .wr_addr (ch_reg),
    .wr_data (conv_result),
    .rd_addr (paddr[5:2]),
    .rd_data (mem_rdata)
  );

  // --------------------------------------------------
  // interrupt
  // --------------------------------------------------
  irq_unit u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .evt        (evt & {`EVT_W{~mode_reg[`MODE_DMA_BIT]}}),
    .en_wr      (wr_now & hit(paddr, `OFS_IRQ_ENABLE)),
    .clr_wr     (wr_now & hit(paddr, `OFS_IRQ_CLEAR)),
    .wdata      (pwdata[`EVT_W-1:0]),
    .status_reg (irq_status),
    .enable_reg (irq_enable),
    .irq        (irq_w)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_w;
    end
  end

endmodule

//--- adc_sequencer_checker.sv
`timescale 1ns/1ps
module adc_sequencer_checker (
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  // core and requests
  input logic        conv_start,
  input logic [3:0]  conv_channel,
  input logic        conv_compare,
  input logic        conv_done,
  input logic        dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       go_wr;
  logic       scan_reg;
  logic [3:0] prev_reg;
  assign go_wr = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[8];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_reg <= 1'b0;
      prev_reg <= 4'h0;
    end else begin
      if (go_wr) scan_reg <= pwdata[0] && !pwdata[1];
      if (conv_start) prev_reg <= conv_channel;
    end
  end
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_slverr; pslverr |-> pready && psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr outside transfer");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_cmp_single; conv_done && conv_compare |=> !conv_start [*3]; endproperty
  a_cmp_single: assert property (p_cmp_single) else $error("compare went on");
  property p_scan_zero; go_wr && pwdata[0] && !pwdata[1] |=> conv_start && conv_channel == 4'h0; endproperty
  a_scan_zero: assert property (p_scan_zero) else $error("scan not from zero");
  property p_ascend; conv_start && scan_reg && conv_channel != 4'h0 |-> conv_channel == prev_reg + 4'h1; endproperty
  a_ascend: assert property (p_ascend) else $error("scan order broken");
  property p_dma_cause; dma_req |-> $past(conv_done); endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma without completion");
  c_scan: cover property (go_wr && pwdata[0]);
  c_dma: cover property (dma_req);
  c_err: cover property (pslverr);
endmodule

bind adc_sequencer adc_sequencer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_compare(conv_compare), .conv_done(conv_done), .dma_req(dma_req));

//--- adc_sequencer_tb.sv
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_sequencer_tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        conv_done = 0;
  logic        cmp_flag = 0;
  logic [9:0]  conv_result = 0;
  logic [31:0] prdata, rd;
  logic [3:0]  conv_channel;
  logic        pready, pslverr, conv_start, conv_compare, irq, dma_req, err;
  logic [2:0]  wcnt = 0;
  logic [1:0]  tag = 0;
  logic [3:0]  chq[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          i;
  always #12.5 pclk = ~pclk;
  adc_sequencer dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_compare(conv_compare), .conv_done(conv_done), .conv_result(conv_result),
    .cmp_flag(cmp_flag), .irq(irq), .dma_req(dma_req));
  // ----
  // converter core stand-in
  // ----
  always @(posedge pclk) begin
    conv_done <= 1'b0;
    if (dma_req) tag <= tag + 2'd1;
    if (conv_start) begin
      chq.push_back(conv_channel);
      wcnt <= 3'd6;
    end else if (wcnt == 3'd1) begin
      conv_done <= 1'b1;
      conv_result <= {conv_channel, conv_channel, tag};
      cmp_flag <= conv_channel[1];
      wcnt <= 3'd0;
    end else if (wcnt != 3'd0) begin
      wcnt <= wcnt - 3'd1;
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 60);
    if (rd[0] !== 1'b0) n_mismatch++;
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
    chk("irq_enable_reset", rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h3);
    apb(1'b1, `OFS_SINGLE_CTRL1, 32'h5);
    apb(1'b1, `OFS_MODE_CTRL, 32'h100);
    idle();
    chk("single_count", chq.size(), 32'h1);
    chk("single_chan", chq[0], 32'h5);
    chk("single_irq", irq, 1'b1);
    apb(1'b0, `OFS_RESULT10_BASE + 12'h014, 32'h0);
    chk("res10_ch5", rd, 32'h154);
    apb(1'b0, `OFS_RESULT8_BASE + 12'h014, 32'h0);
    chk("res8_ch5", rd, 32'h55);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h3);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("irq_cleared", {rd[30:0], irq}, 32'h0);
    chq.delete();
    apb(1'b1, `OFS_SINGLE_CTRL1, 32'h6);
    apb(1'b1, `OFS_MODE_CTRL, 32'h103);
    idle();
    chk("cmp_count", chq.size(), 32'h1);
    chk("cmp_chan", {chq[0], conv_compare}, 5'h0d);
    apb(1'b0, `OFS_CMP_RESULT, 32'h0);
    chk("cmp_flag", rd[6], 1'b1);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("cmp_done", rd, 32'h1);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h3);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
    apb(1'b1, `OFS_SCAN_CTRL0, 32'h0);
    apb(1'b1, `OFS_SCAN_CTRL1, 32'h3);
    chq.delete();
    apb(1'b1, `OFS_MODE_CTRL, 32'h101);
    idle();
    chk("shot_count", chq.size(), 32'h4);
    for (i = 0; i < 4; i++) begin
      chk("shot_order", chq[i], i);
      apb(1'b0, `OFS_RESULT10_BASE + 12'(4 * i), 32'h0);
      chk("shot_res", rd, {22'h0, 4'(i), 4'(i), 2'h0});
    end
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("pass_done_masked", {rd[30:0], irq}, 32'h4);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h3);
    apb(1'b1, `OFS_SCAN_CTRL1, 32'h2);
    apb(1'b1, `OFS_SCAN_CTRL0, 32'h1);
    chq.delete();
    apb(1'b1, `OFS_MODE_CTRL, 32'h105);
    i = 0;
    while (tag != 2'd2 && i < 400) begin
      @(posedge pclk);
      i++;
    end
    apb(1'b1, `OFS_SCAN_CTRL0, 32'h5);
    idle();
    repeat (30) @(posedge pclk);
    chk("no_dma_after_stop", tag, 2'd2);
    for (i = 0; i < 6; i++) chk("cont_order", chq[i], i % 3);
    apb(1'b0, `OFS_RESULT10_BASE + 12'h008, 32'h0);
    chk("cont_res_ch2", rd, 32'h089);
    apb(1'b0, `OFS_RESULT10_BASE, 32'h0);
    chk("stop_keeps_ch0", rd, 32'h001);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("dma_path_no_irq", rd, 32'h0);
    apb(1'b0, `OFS_SCAN_CTRL0, 32'h0);
    chk("scan_ctrl0", rd, 32'h1);
    summarize();
  end
endmodule

//--- irq_unit.v
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module irq_unit (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  input  wire              ce,
  // events
  input  wire [`EVT_W-1:0] evt,
  // software access
  input  wire              en_wr,
  input  wire              clr_wr,
  input  wire [`EVT_W-1:0] wdata,
  // state
  output reg  [`EVT_W-1:0] status_reg,
  output reg  [`EVT_W-1:0] enable_reg,
  output reg               irq
);

  wire [`EVT_W-1:0] status_next;
  wire [`EVT_W-1:0] enable_next;

  // set wins over a clear in the same cycle
  assign status_next = (status_reg & ~(clr_wr ? wdata : `EVT_RST)) | evt;
  assign enable_next = en_wr ? wdata : enable_reg;

  // --------------------------------------------------
  // sticky status, enable, level output
  // --------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `EVT_RST;
      enable_reg <= `EVT_RST;
      irq        <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq        <= |(status_next & enable_next);
    end
  end

endmodule

//--- result_mem.v
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module result_mem (
  // clock
  input  wire                 pclk,
  input  wire                 ce,
  // write port
  input  wire                 wr_en,
  input  wire [`CH_W-1:0]     wr_addr,
  input  wire [`RESULT_W-1:0] wr_data,
  // read port
  input  wire [`CH_W-1:0]     rd_addr,
  output reg  [`RESULT_W-1:0] rd_data
);

  reg [`RESULT_W-1:0] mem [0:`NUM_CHANNELS-1];

  // --------------------------------------------------
  // storage
  // --------------------------------------------------
  always @(posedge pclk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule
